// ===== core/tmc_channel2.sv
// timer channel 2: prescaler, down counter, input capture, dma request
//
// What this block does
// R1: capture enabled: a capture requests a DMA transfer unless one is still pending
// R2: software sets external pin as input first
// R3: capture register updated only while flag is 0
// R4: DMA request independent of capture flag state
// R5: no new request until previous one finished
// R6: prescaler codes pick divide by 4/16/64/1024
// R7: 110 counts RTC, 111 external pin; 101 reserved
// R8: edge field picks rising, falling or both
// R9: underflow interrupt gated by its enable bit
// R10: capture control: off, on, on with interrupt
// R11: underflow flag: write 0 clears, 1 ignored
// R12: hard reset clears all control fields
// R13: prescaler code 011 divides by 256
// R14: underflow sets flag, reloads, keeps counting
// R15: capture sets flag; write 0 clears it
// R16: pins synchronised, edges become single pulses
//
// Strobed register access was decided locally.
`default_nettype none
module tmc_channel2
    import tmc_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire tmc_bus_type       i_bus,
    input  wire logic              i_ext_timer_clock_pin,
    input  wire logic              i_rtc_clock,
    input  wire logic              i_dma_done,
    output logic [DATA_W-1:0]      o_rdata,
    output logic                   o_dma_req,
    output logic                   o_underflow_irq,
    output logic                   o_capture_irq
);
    typedef struct packed {
        tmc_ctl_type       ctl;
        logic              start;
        logic [31:0]       cnt;
        logic [31:0]       cnst;
        logic [31:0]       capt;
        logic [DIV_W-1:0]  div;
        logic              pin_meta;
        logic              pin_sync;
        logic              pin_prev;
        logic              rtc_meta;
        logic              rtc_sync;
        logic              rtc_prev;
        logic              dma_req;
        logic              uflow_irq;
        logic              cap_irq;
        logic [DATA_W-1:0] rdata;
    } tmc_state_type;

    tmc_state_type st_ff;
    tmc_state_type nxt_st;

    logic        pin_rise;
    logic        pin_fall;
    logic        pin_edge;
    logic        rtc_rise;
    logic        div_tick;
    logic        cnt_tick;
    logic        underflow;
    logic        cap_evt;
    tmc_ctl_type wr_ctl;

    always_comb begin
        nxt_st = st_ff;
        // control write data seen through the field layout
        wr_ctl = tmc_ctl_type'(i_bus.wdata[CTL_W-1:0]);
        // the first stage is looked at only by the second stage
        nxt_st.pin_meta = i_ext_timer_clock_pin;
        nxt_st.pin_sync = st_ff.pin_meta;
        nxt_st.pin_prev = st_ff.pin_sync;
        nxt_st.rtc_meta = i_rtc_clock;
        nxt_st.rtc_sync = st_ff.rtc_meta;
        nxt_st.rtc_prev = st_ff.rtc_sync;
        nxt_st.div      = st_ff.div + DIV_W'(1);

        // R16: single-cycle edges
        pin_rise = st_ff.pin_sync & ~st_ff.pin_prev;
        pin_fall = ~st_ff.pin_sync & st_ff.pin_prev;
        rtc_rise = st_ff.rtc_sync & ~st_ff.rtc_prev;
        // R8: edge choice
        case (st_ff.ctl.edge_sel)
            EDGE_RISE: pin_edge = pin_rise;
            EDGE_FALL: pin_edge = pin_fall;
            default:   pin_edge = pin_rise | pin_fall;
        endcase

        // R6: internal divide ratios
        case (st_ff.ctl.psc)
            PSC_DIV4:    div_tick = (st_ff.div & MASK_DIV4) == MASK_DIV4;
            PSC_DIV16:   div_tick = (st_ff.div & MASK_DIV16) == MASK_DIV16;
            PSC_DIV64:   div_tick = (st_ff.div & MASK_DIV64) == MASK_DIV64;
            // R13: code 011 is divide by 256
            PSC_DIV256:  div_tick = (st_ff.div & MASK_DIV256) == MASK_DIV256;
            PSC_DIV1024: div_tick = st_ff.div == MASK_DIV1024;
            default:     div_tick = 1'b0;
        endcase
        // R7: rtc and pin sources; reserved code never counts
        case (st_ff.ctl.psc)
            PSC_RTC: cnt_tick = rtc_rise;
            PSC_EXT: cnt_tick = pin_edge;
            default: cnt_tick = div_tick;
        endcase
        cnt_tick  = cnt_tick & st_ff.start;
        underflow = cnt_tick && (st_ff.cnt == '0);
        // R10: reserved 01 has the upper bit clear, so it stays off
        cap_evt   = st_ff.ctl.capture_control[1] & pin_edge;

        // R14: reload on underflow, otherwise count down
        if (cnt_tick) begin
            nxt_st.cnt = underflow ? st_ff.cnst : st_ff.cnt - 32'h1;
        end

        // register writes; hardware sets below override clears
        if (i_bus.wr) begin
            case (i_bus.addr)
                OFF_CONST: nxt_st.cnst = i_bus.wdata;
                OFF_COUNT: nxt_st.cnt  = i_bus.wdata;
                OFF_START: nxt_st.start = i_bus.wdata[START_BIT];
                OFF_CTRL: begin
                    nxt_st.ctl.psc      = wr_ctl.psc;
                    nxt_st.ctl.edge_sel = wr_ctl.edge_sel;
                    nxt_st.ctl.underflow_irq_enable =
                        wr_ctl.underflow_irq_enable;
                    nxt_st.ctl.capture_control = wr_ctl.capture_control;
                    // R11: write 0 clears, write 1 keeps
                    if (!i_bus.wdata[UFLAG_BIT]) begin
                        nxt_st.ctl.underflow_flag = 1'b0;
                    end
                    // R15: same clear manner for the capture flag
                    if (!i_bus.wdata[CFLAG_BIT]) begin
                        nxt_st.ctl.capture_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // R14: set wins over a same-cycle clear
        if (underflow) begin
            nxt_st.ctl.underflow_flag = 1'b1;
        end
        // R3: copy only while the flag was clear
        if (cap_evt && !st_ff.ctl.capture_flag) begin
            nxt_st.capt = st_ff.cnt;
        end
        // R15: capture sets its flag
        if (cap_evt) begin
            nxt_st.ctl.capture_flag = 1'b1;
        end

        // R5: request held until the controller reports done
        if (i_dma_done) begin
            nxt_st.dma_req = 1'b0;
        end
        // R1: capture raises a request; R4: flag plays no part
        if (cap_evt && (!st_ff.dma_req || i_dma_done)) begin
            nxt_st.dma_req = 1'b1;
        end

        // R9: underflow interrupt gated by enable
        nxt_st.uflow_irq = nxt_st.ctl.underflow_flag
                         & nxt_st.ctl.underflow_irq_enable;
        // R10: capture interrupt only with code 11
        nxt_st.cap_irq = nxt_st.ctl.capture_flag
                       & (nxt_st.ctl.capture_control == CAPCTL_IRQ);

        nxt_st.rdata = '0;
        if (i_bus.rd) begin
            case (i_bus.addr)
                OFF_CONST: nxt_st.rdata = st_ff.cnst;
                OFF_COUNT: nxt_st.rdata = st_ff.cnt;
                OFF_CTRL:  nxt_st.rdata = DATA_W'(st_ff.ctl);
                OFF_CAPT:  nxt_st.rdata = st_ff.capt;
                OFF_START: nxt_st.rdata = DATA_W'(st_ff.start);
                default:   nxt_st.rdata = '0;
            endcase
        end

        // R12: hard reset clears control, wide registers to all ones
        if (i_rst) begin
            nxt_st      = '0;
            nxt_st.capt = CAPT_RST;
            nxt_st.cnt  = COUNT_RST;
            nxt_st.cnst = CONST_RST;
        end
    end

    always_ff @(posedge i_clk) begin
        st_ff <= nxt_st;
    end

    assign o_rdata         = st_ff.rdata;
    assign o_dma_req       = st_ff.dma_req;
    assign o_underflow_irq = st_ff.uflow_irq;
    assign o_capture_irq   = st_ff.cap_irq;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_dma_on_capture: assert property ( // R1 R4
        cap_evt && !st_ff.dma_req |=> o_dma_req)
        else $error("capture without dma request");
    a_dma_held: assert property ( // R5
        o_dma_req && !i_dma_done |=> o_dma_req)
        else $error("dma request dropped before done");
    a_capture_kept: assert property ( // R3
        cap_evt && st_ff.ctl.capture_flag && !i_bus.wr
            |=> $stable(st_ff.capt))
        else $error("capture register overwritten while flag set");
    a_capture_copy: assert property ( // R3
        cap_evt && !st_ff.ctl.capture_flag
            |=> st_ff.capt == $past(st_ff.cnt))
        else $error("capture register missed counter value");
    a_capture_flag: assert property ( // R15
        cap_evt |=> st_ff.ctl.capture_flag)
        else $error("capture flag not set");
    a_uflow_irq_on: assert property ( // R9 R14
        underflow && st_ff.ctl.underflow_irq_enable && !i_bus.wr
            |=> o_underflow_irq)
        else $error("underflow interrupt missing");
    a_uflow_irq_gate: assert property ( // R9
        !st_ff.ctl.underflow_irq_enable |-> !o_underflow_irq)
        else $error("underflow interrupt while disabled");
    a_reload_value: assert property ( // R14
        underflow && !i_bus.wr |=> st_ff.cnt == $past(st_ff.cnst))
        else $error("counter not reloaded");
    a_uflow_write_one: assert property ( // R11
        st_ff.ctl.underflow_flag && i_bus.wr && i_bus.addr == OFF_CTRL
            && i_bus.wdata[UFLAG_BIT] |=> st_ff.ctl.underflow_flag)
        else $error("underflow flag cleared by writing one");
    a_reset_ctl: assert property ( // R12
        $past(i_rst) |-> st_ff.ctl == '0 && !o_dma_req)
        else $error("control not cleared by reset");
endmodule
`default_nettype wire

// ===== core/tmc_pkg.sv
// constants and carrier types for the timer channel 2 capture block
`default_nettype none
package tmc_pkg;
    localparam int          ADDR_W    = 8;
    localparam int          DATA_W    = 32;
    localparam int          CTL_W     = 10;
    localparam int          DIV_W     = 10;
    // register byte offsets
    localparam logic [7:0]  OFF_CONST = 8'h20;
    localparam logic [7:0]  OFF_COUNT = 8'h24;
    localparam logic [7:0]  OFF_CTRL  = 8'h28;
    localparam logic [7:0]  OFF_CAPT  = 8'h2c;
    localparam logic [7:0]  OFF_START = 8'h30;
    // bit positions used directly by the write logic
    localparam int          UFLAG_BIT = 8;
    localparam int          CFLAG_BIT = 9;
    localparam int          START_BIT = 0;
    // count clock selection codes
    localparam logic [2:0]  PSC_DIV4    = 3'h0;
    localparam logic [2:0]  PSC_DIV16   = 3'h1;
    localparam logic [2:0]  PSC_DIV64   = 3'h2;
    localparam logic [2:0]  PSC_DIV256  = 3'h3;
    localparam logic [2:0]  PSC_DIV1024 = 3'h4;
    localparam logic [2:0]  PSC_RTC     = 3'h6;
    localparam logic [2:0]  PSC_EXT     = 3'h7;
    // divider terminal masks
    localparam logic [9:0]  MASK_DIV4    = 10'h003;
    localparam logic [9:0]  MASK_DIV16   = 10'h00f;
    localparam logic [9:0]  MASK_DIV64   = 10'h03f;
    localparam logic [9:0]  MASK_DIV256  = 10'h0ff;
    localparam logic [9:0]  MASK_DIV1024 = 10'h3ff;
    // edge and capture control codes
    localparam logic [1:0]  EDGE_RISE = 2'h0;
    localparam logic [1:0]  EDGE_FALL = 2'h1;
    localparam logic [1:0]  CAPCTL_IRQ = 2'h3;
    // reset values of the wide registers
    localparam logic [31:0] CAPT_RST  = 32'hffffffff;
    localparam logic [31:0] COUNT_RST = 32'hffffffff;
    localparam logic [31:0] CONST_RST = 32'hffffffff;

    // field order matches bits 9 down to 0 of the control register
    typedef struct packed {
        logic       capture_flag;
        logic       underflow_flag;
        logic [1:0] capture_control;
        logic       underflow_irq_enable;
        logic [1:0] edge_sel;
        logic [2:0] psc;
    } tmc_ctl_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tmc_bus_type;
endpackage
`default_nettype wire

// ===== testbench/tb_tmc_channel2.sv
// self-checking bench for the channel 2 capture block
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module tb_tmc_channel2
    import tmc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk, i_rst, pin, rtc, done, req, uirq, cirq, req_q;
    tmc_bus_type bus;
    logic [31:0] rdata, d, x;
    logic [7:0]  delay;
    int          failures, check_count, rises, n;

    tmc_channel2 u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus),
        .i_ext_timer_clock_pin(pin), .i_rtc_clock(rtc), .i_dma_done(done),
        .o_rdata(rdata), .o_dma_req(req), .o_underflow_irq(uirq),
        .o_capture_irq(cirq));
    tmc_dma_model u_dma (.i_clk(i_clk), .i_rst(i_rst), .i_dma_req(req),
        .i_delay(delay), .o_dma_done(done));

    function automatic logic [31:0] ctl(logic [2:0] p, logic [1:0] e,
            logic u, logic [1:0] c, logic [1:0] f);
        return {22'h0, f, c, u, e, p};
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    // the pin is only ever an input of the block
    task automatic pin_to(logic v);
        @(posedge i_clk);
        pin <= v;
        repeat (10) @(posedge i_clk);
    endtask
    task automatic give_verdict;
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        req_q <= req;
        if (req === 1'b1 && req_q === 1'b0)
            rises++;
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        failures++;
        give_verdict();
    end

    initial begin
        i_rst = 1'b1;
        bus = '0;
        pin = 1'b0;
        rtc = 1'b0;
        delay = 8'd0;
        void'($urandom(33));
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(OFF_CTRL, d);
        `CHK(d, 32'h0)
        rd(OFF_CAPT, d);
        `CHK(d, CAPT_RST)
        rd(8'h3c, d);
        `CHK(d, 32'h0)
        // divide ratio seen as time from start to the second tick, which underflows
        for (int p = 0; p < 5; p++) begin
            x = $urandom;
            wr(OFF_CONST, x);
            wr(OFF_COUNT, 32'h1);
            wr(OFF_CTRL, ctl(3'(p), 2'h0, 1'b1, 2'h0, 2'h0));
            wr(OFF_START, 32'h1);
            n = 0;
            while (uirq !== 1'b1 && n < 2100) begin
                @(posedge i_clk);
                n++;
            end
            wr(OFF_START, 32'h0);
            rd(OFF_COUNT, d);
            `CHK(d === x || d === x - 1, 1'b1)
            `CHK(n > (4 << 2*p) - 3 && n < (8 << 2*p) + 3, 1'b1)
            wr(OFF_CTRL, ctl(3'(p), 2'h0, 1'b0, 2'h0, 2'h1));
            rd(OFF_CTRL, d);
            `CHK(d[8], 1'b1)
            `CHK(uirq, 1'b0)
            wr(OFF_CTRL, ctl(3'(p), 2'h0, 1'b1, 2'h0, 2'h1));
            // interrupt launched at the write edge, seen one edge on
            @(posedge i_clk);
            `CHK(uirq, 1'b1)
        end
        delay <= 8'd0;
        wr(OFF_CTRL, ctl(3'h0, 2'h0, 1'b0, 2'h2, 2'h0));
        x = $urandom;
        wr(OFF_COUNT, x);
        n = rises;
        pin_to(1'b1);
        rd(OFF_CAPT, d);
        `CHK(d, x)
        `CHK(rises, n + 1)
        wr(OFF_COUNT, ~x);
        pin_to(1'b0);
        pin_to(1'b1);
        rd(OFF_CAPT, d);
        `CHK(d, x)
        `CHK(rises, n + 2)
        rd(OFF_CTRL, d);
        `CHK(d[9], 1'b1)
        // slow controller: later captures fold into the pending request
        delay <= 8'd60;
        repeat (2) begin
            pin_to(1'b0);
            pin_to(1'b1);
        end
        `CHK(rises, n + 3)
        repeat (40) @(posedge i_clk);
        `CHK(req, 1'b0)
        delay <= 8'd0;
        pin_to(1'b0);
        for (int c = 0; c < 4; c++) begin
            // reserved capture code 01 is never written
            for (int e = 0; e < 4 && c != 1; e++) begin
                wr(OFF_CTRL, ctl(3'h0, 2'(e), 1'b0, 2'(c), 2'h0));
                n = rises;
                pin_to(1'b1);
                pin_to(1'b0);
                `CHK(rises - n, c[1] ? (e[1] ? 2 : 1) : 0)
                `CHK(cirq, c == 3)
            end
        end
        x = $urandom | 32'h100;
        wr(OFF_COUNT, x);
        wr(OFF_CTRL, ctl(PSC_EXT, 2'h2, 1'b0, 2'h0, 2'h0));
        wr(OFF_START, 32'h1);
        repeat (2) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        wr(OFF_CTRL, ctl(PSC_RTC, 2'h0, 1'b0, 2'h0, 2'h0));
        repeat (3) begin
            @(posedge i_clk) rtc <= 1'b1;
            repeat (5) @(posedge i_clk);
            rtc <= 1'b0;
            repeat (5) @(posedge i_clk);
        end
        wr(OFF_START, 32'h0);
        rd(OFF_COUNT, d);
        `CHK(d, x - 7)
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== testbench/tmc_dma_model.sv
// dma controller stand-in that answers transfer requests
`default_nettype none
module tmc_dma_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_dma_req,
    input  wire logic [7:0] i_delay,
    output logic            o_dma_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wait_ff;
    logic       busy_ff;
    // one done pulse per request, then rest a cycle
    always_ff @(posedge i_clk) begin
        o_dma_done <= 1'b0;
        if (i_rst) begin
            busy_ff <= 1'b0;
            wait_ff <= 8'h00;
        end else if (!busy_ff && i_dma_req) begin
            busy_ff <= 1'b1;
            wait_ff <= i_delay;
        end else if (busy_ff && wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
        end else if (busy_ff && !o_dma_done) begin
            o_dma_done <= 1'b1;
        end else if (busy_ff) begin
            busy_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire
